// ===== logic/lspec_tracker.sv
// Purpose: Advanced load address table, deferred fault flags and spill/fill collection
// Assumes: One operation request per clock; response registered one cycle later
// Notes:   Wishbone slave answers every access one cycle after the strobe is seen
// Behaviour
// (RULE_01) An advanced load allocates a table entry for its destination register.
// (RULE_02) Entries are keyed by register number and hold address, load kind, size.
// (RULE_03) Checks match register number and kind; a hit continues normally.
// (RULE_04) Advanced check branch redirects to its offset target when no entry matches.
// (RULE_05) Check load reloads on a miss and does nothing extra on a hit.
// (RULE_06) A store overlapping an entry's address range removes that entry.
// (RULE_07) A later advanced load to the same register displaces the older entry.
// (RULE_08) Entries may be dropped for capacity or flush; dropped entries make checks miss.
// (RULE_09) Software checks before any non-speculative use of an advanced load result.
// (RULE_10) Software names the same register in the check as in the advanced load.
// (RULE_11) Every general register carries one deferred fault flag.
// (RULE_12) Float registers mark a deferred fault with a special encoded value.
// (RULE_13) A faulting control speculative load sets its destination flag, no fault.
// (RULE_14) Speculative ops reading a flagged source flag all their targets.
// (RULE_15) Non-speculative ops other than the speculation check fault on flagged sources; only stores and ALU ops fault here.
// (RULE_16) Speculation check branch redirects when the checked flag is set.
// (RULE_17) Test ops report flags and float deferred values without faulting.
// (RULE_18) General spill copies the flag into collection bit chosen by address 8:3.
// (RULE_19) General fill sets the register flag from the selected collection bit.
// (RULE_20) Float spill and fill never fault on the deferred fault float value.
// (RULE_21) Software saves and restores the collection register itself.
// (RULE_22) A speculative advanced load producing a deferred fault allocates no entry.
// (RULE_23) With no free entry an existing one is evicted for the new load.
// (RULE_24) Reset marks every table entry invalid.
`timescale 1ns/10ps

module lspec_tracker #(
  parameter int ADVANCED_LOAD_ADDRESS_TABLE_USED = lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP
) (
  input  wire logic                    core_clk, // Core clock, 50 MHz
  input  wire logic                    rst_b,    // Asynchronous reset, active low
  input  wire lspec_pkg::lspec_wb_req_t wb_i,    // Wishbone request from master
  output      lspec_pkg::lspec_wb_rsp_t wb_o,    // Wishbone ack and read data
  input  wire lspec_pkg::lspec_req_t    op_i,    // Operation from issue logic
  output      lspec_pkg::lspec_rsp_t    rsp_o    // Registered operation outcome
);

  generate
    if (ADVANCED_LOAD_ADDRESS_TABLE_USED < 1 || ADVANCED_LOAD_ADDRESS_TABLE_USED > lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP) begin : g_bad_depth
      $error("ADVANCED_LOAD_ADDRESS_TABLE_USED out of range");
    end
  endgenerate

  localparam logic [lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_IDX_W-1:0] LAST_IDX = lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_IDX_W'(ADVANCED_LOAD_ADDRESS_TABLE_USED - 1);

  lspec_pkg::lspec_state_t s_reg;
  lspec_pkg::lspec_state_t s_next;

  logic [lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP-1:0] same_reg;
  logic [lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP-1:0] chk_match;
  logic [lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP-1:0] overlap;
  logic [lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP-1:0] valid_vec;

  // End of a byte range, one bit wider so it cannot wrap
  function automatic logic [lspec_pkg::ADDR_W:0] range_end(
    input logic [lspec_pkg::ADDR_W-1:0] base,
    input logic [lspec_pkg::SIZE_W-1:0] size
  );
    logic [lspec_pkg::ADDR_W:0] len;
    len = (lspec_pkg::ADDR_W+1)'(1) << size;
    return {1'b0, base} + len;
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP; gi++) begin : g_entry
      lspec_pkg::lspec_entry_t e;
      assign e = s_reg.advanced_load_address_table[gi];
      assign valid_vec[gi] = e.valid;
      assign same_reg[gi]  = e.valid && (e.preg == op_i.dst);                       // [RULE_02]
      assign chk_match[gi] = e.valid && (e.preg == op_i.dst) && (e.kind == op_i.kind); // [RULE_03]
      assign overlap[gi]   = e.valid
                             && ({1'b0, op_i.addr} < range_end(e.addr, e.size))
                             && ({1'b0, e.addr} < range_end(op_i.addr, op_i.size)); // [RULE_06]
    end
  endgenerate

  always_comb begin
    logic                               hit;
    logic                               src_flag;
    logic                               do_alloc;
    logic                               found;
    logic [lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_IDX_W-1:0]   slot;
    logic [lspec_pkg::COLL_SEL_MSB-lspec_pkg::COLL_SEL_LSB:0] csel;
    logic [31:0]                        ctrl_now;
    logic [31:0]                        wval;
    lspec_pkg::lspec_entry_t            ne;

    hit      = |chk_match;
    src_flag = s_reg.deferred_fault_flag[op_i.src1] | s_reg.deferred_fault_flag[op_i.src2];
    do_alloc = 1'b0;
    found    = 1'b0;
    slot     = s_reg.victim;
    csel     = op_i.addr[lspec_pkg::COLL_SEL_MSB:lspec_pkg::COLL_SEL_LSB];
    ctrl_now = 32'h0;
    ctrl_now[lspec_pkg::CTRL_ENABLE_BIT] = s_reg.enable;
    wval     = 32'h0;
    ne       = '0;

    s_next        = s_reg;
    s_next.rsp    = '0;
    s_next.wb_ack = 1'b0;

    // Register bus: one-cycle ack, unmapped reads return zero
    if (wb_i.cyc && wb_i.stb && !s_reg.wb_ack) begin
      s_next.wb_ack = 1'b1;
      unique case (wb_i.adr)
        lspec_pkg::REG_CTRL:    s_next.wb_dat = ctrl_now;
        lspec_pkg::REG_STATUS:  s_next.wb_dat = {16'h0, valid_vec};
        lspec_pkg::REG_COLL_LO: s_next.wb_dat = s_reg.coll[31:0];
        lspec_pkg::REG_COLL_HI: s_next.wb_dat = s_reg.coll[63:32];
        default:                s_next.wb_dat = 32'h0;
      endcase
      if (wb_i.we) begin
        unique case (wb_i.adr)
          lspec_pkg::REG_CTRL: begin
            wval = lane_merge(ctrl_now, wb_i.dat, wb_i.sel);
            s_next.enable = wval[lspec_pkg::CTRL_ENABLE_BIT];
            if (wb_i.sel[0] && wb_i.dat[lspec_pkg::CTRL_FLUSH_BIT]) begin
              for (int i = 0; i < lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP; i++) begin
                s_next.advanced_load_address_table[i].valid = 1'b0; // [RULE_08]
              end
            end
          end
          lspec_pkg::REG_COLL_LO: s_next.coll[31:0]  = lane_merge(s_reg.coll[31:0], wb_i.dat, wb_i.sel);  // [RULE_21]
          lspec_pkg::REG_COLL_HI: s_next.coll[63:32] = lane_merge(s_reg.coll[63:32], wb_i.dat, wb_i.sel); // [RULE_21]
          default: ;
        endcase
      end
    end

    // Operation processing; runs after the bus so hardware updates win
    if (op_i.valid) begin
      s_next.rsp.valid = 1'b1;
      s_next.rsp.hit   = hit;
      unique case (op_i.op)
        lspec_pkg::OP_ADV_LOAD,
        lspec_pkg::OP_SPEC_ADV_LOAD: begin
          for (int i = 0; i < lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP; i++) begin
            if (same_reg[i]) begin
              s_next.advanced_load_address_table[i].valid = 1'b0; // [RULE_07]
            end
          end
          if (op_i.op == lspec_pkg::OP_SPEC_ADV_LOAD) begin
            s_next.deferred_fault_flag[op_i.dst] = op_i.fault; // [RULE_13]
          end else begin
            s_next.deferred_fault_flag[op_i.dst] = 1'b0;
          end
          do_alloc = s_reg.enable && !(op_i.op == lspec_pkg::OP_SPEC_ADV_LOAD && op_i.fault); // [RULE_22]
          for (int i = 0; i < ADVANCED_LOAD_ADDRESS_TABLE_USED; i++) begin
            if (!found && (same_reg[i] || !valid_vec[i])) begin
              found = 1'b1;
              slot  = lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_IDX_W'(i);
            end
          end
          if (do_alloc) begin
            ne.valid = 1'b1;
            ne.preg  = op_i.dst;
            ne.addr  = op_i.addr;
            ne.kind  = op_i.kind;
            ne.size  = op_i.size;
            s_next.advanced_load_address_table[slot] = ne; // [RULE_01] [RULE_02]
            if (!found) begin
              s_next.victim = (s_reg.victim == LAST_IDX) ? '0 : s_reg.victim + 1'b1; // [RULE_23] [RULE_08]
            end
          end
        end
        lspec_pkg::OP_CTRL_SPEC_LOAD: begin
          if (op_i.fp_dst) begin
            s_next.rsp.fp_write  = op_i.fault;
            s_next.rsp.fp_result = lspec_pkg::DEFERRED_FAULT_FLOAT_VALUE; // [RULE_12]
          end else begin
            s_next.deferred_fault_flag[op_i.dst] = op_i.fault; // [RULE_13] [RULE_11]
          end
        end
        lspec_pkg::OP_CHECK_LOAD: begin
          s_next.rsp.reload = !hit; // [RULE_05]
          if (!hit) begin
            s_next.deferred_fault_flag[op_i.dst] = 1'b0;
          end
        end
        lspec_pkg::OP_CHECK_ADV_BR: begin
          s_next.rsp.redirect = !hit; // [RULE_04]
          s_next.rsp.target   = op_i.pc + {{(lspec_pkg::ADDR_W-lspec_pkg::OFFS_W){op_i.offset[lspec_pkg::OFFS_W-1]}},
                                           op_i.offset};
        end
        lspec_pkg::OP_SPEC_CHECK_BR: begin
          s_next.rsp.redirect = s_reg.deferred_fault_flag[op_i.src1]; // [RULE_16]
          s_next.rsp.target   = op_i.pc + {{(lspec_pkg::ADDR_W-lspec_pkg::OFFS_W){op_i.offset[lspec_pkg::OFFS_W-1]}},
                                           op_i.offset};
        end
        lspec_pkg::OP_STORE: begin
          if (src_flag) begin
            s_next.rsp.cons_fault = 1'b1; // [RULE_15]
          end else begin
            for (int i = 0; i < lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP; i++) begin
              if (overlap[i]) begin
                s_next.advanced_load_address_table[i].valid = 1'b0; // [RULE_06]
              end
            end
          end
        end
        lspec_pkg::OP_GR_SPILL,
        lspec_pkg::OP_FP_SPILL: begin
          for (int i = 0; i < lspec_pkg::ADVANCED_LOAD_ADDRESS_TABLE_CAP; i++) begin
            if (overlap[i]) begin
              s_next.advanced_load_address_table[i].valid = 1'b0; // [RULE_06] [RULE_20]
            end
          end
          if (op_i.op == lspec_pkg::OP_GR_SPILL) begin
            s_next.coll[csel] = s_reg.deferred_fault_flag[op_i.src1]; // [RULE_18]
          end
        end
        lspec_pkg::OP_GR_FILL: begin
          s_next.deferred_fault_flag[op_i.dst] = s_reg.coll[csel]; // [RULE_19]
        end
        lspec_pkg::OP_FP_FILL: begin
          s_next.rsp.fp_write  = 1'b1;
          s_next.rsp.fp_result = op_i.fp_val; // [RULE_20]
        end
        lspec_pkg::OP_ALU: begin
          if (op_i.spec) begin
            s_next.deferred_fault_flag[op_i.dst] = src_flag; // [RULE_14]
          end else if (src_flag) begin
            s_next.rsp.cons_fault = 1'b1; // [RULE_15]
          end else begin
            s_next.deferred_fault_flag[op_i.dst] = 1'b0;
          end
        end
        lspec_pkg::OP_TEST_GR: begin
          s_next.rsp.test_set = s_reg.deferred_fault_flag[op_i.src1]; // [RULE_17]
        end
        lspec_pkg::OP_TEST_FP: begin
          s_next.rsp.test_set = (op_i.fp_val == lspec_pkg::DEFERRED_FAULT_FLOAT_VALUE); // [RULE_17] [RULE_12]
        end
        default: s_next.rsp = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg        <= '0; // [RULE_24]
      s_reg.enable <= lspec_pkg::CTRL_RESET[lspec_pkg::CTRL_ENABLE_BIT];
      s_reg.coll   <= lspec_pkg::COLL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_o.ack = s_reg.wb_ack;
  assign wb_o.dat = s_reg.wb_dat;
  assign rsp_o    = s_reg.rsp;

endmodule

// ===== logic/lspec_pkg.sv
// Purpose: Shared constants and carrier types of the load speculation tracker
// Assumes: One operation per clock from the issue logic; 32-bit classic Wishbone
// Notes:   Table geometry is fixed here; the tracker may use fewer entries
package lspec_pkg;

  // Geometry
  localparam int GR_COUNT   = 128;
  localparam int GR_IDX_W   = 7;
  localparam int ADDR_W     = 64;
  localparam int ADVANCED_LOAD_ADDRESS_TABLE_CAP   = 16;
  localparam int ADVANCED_LOAD_ADDRESS_TABLE_IDX_W = 4;
  localparam int KIND_W     = 2;
  localparam int SIZE_W     = 2;
  localparam int OFFS_W     = 32;
  localparam int FP_W       = 82;
  localparam int COLL_W     = 64;

  // Collection bit select taken from spill or fill address
  localparam int COLL_SEL_LSB = 3;
  localparam int COLL_SEL_MSB = 8;

  // Deferred fault float encoding
  localparam logic [FP_W-1:0] DEFERRED_FAULT_FLOAT_VALUE = 82'h3ffff_ffff_ffff_ffff_ffff;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_COLL_LO = 8'h08;
  localparam logic [7:0] REG_COLL_HI = 8'h0c;

  // Control fields and reset values
  localparam int          CTRL_FLUSH_BIT  = 0;
  localparam int          CTRL_ENABLE_BIT = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0002;
  localparam logic [63:0] COLL_RESET      = 64'h0;

  typedef enum logic [3:0] {
    OP_NONE           = 4'h0,
    OP_ADV_LOAD       = 4'h1,
    OP_SPEC_ADV_LOAD  = 4'h2,
    OP_CTRL_SPEC_LOAD = 4'h3,
    OP_CHECK_LOAD     = 4'h4,
    OP_CHECK_ADV_BR   = 4'h5,
    OP_SPEC_CHECK_BR  = 4'h6,
    OP_STORE          = 4'h7,
    OP_GR_SPILL       = 4'h8,
    OP_GR_FILL        = 4'h9,
    OP_FP_SPILL       = 4'ha,
    OP_FP_FILL        = 4'hb,
    OP_ALU            = 4'hc,
    OP_TEST_GR        = 4'hd,
    OP_TEST_FP        = 4'he
  } lspec_op_t;

  typedef struct packed {
    logic                  valid;
    logic [GR_IDX_W-1:0]   preg;
    logic [ADDR_W-1:0]     addr;
    logic [KIND_W-1:0]     kind;
    logic [SIZE_W-1:0]     size;
  } lspec_entry_t;

  typedef struct packed {
    logic                  valid;
    lspec_op_t             op;
    logic                  spec;
    logic                  fault;
    logic                  fp_dst;
    logic [GR_IDX_W-1:0]   dst;
    logic [GR_IDX_W-1:0]   src1;
    logic [GR_IDX_W-1:0]   src2;
    logic [ADDR_W-1:0]     addr;
    logic [KIND_W-1:0]     kind;
    logic [SIZE_W-1:0]     size;
    logic [ADDR_W-1:0]     pc;
    logic [OFFS_W-1:0]     offset;
    logic [FP_W-1:0]       fp_val;
  } lspec_req_t;

  typedef struct packed {
    logic                  valid;
    logic                  hit;
    logic                  redirect;
    logic [ADDR_W-1:0]     target;
    logic                  reload;
    logic                  cons_fault;
    logic                  test_set;
    logic                  fp_write;
    logic [FP_W-1:0]       fp_result;
  } lspec_rsp_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lspec_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } lspec_wb_rsp_t;

  typedef struct packed {
    lspec_entry_t [ADVANCED_LOAD_ADDRESS_TABLE_CAP-1:0] advanced_load_address_table;
    logic [GR_COUNT-1:0]         deferred_fault_flag;
    logic [COLL_W-1:0]           coll;
    logic [ADVANCED_LOAD_ADDRESS_TABLE_IDX_W-1:0]       victim;
    logic                        enable;
    lspec_rsp_t                  rsp;
    logic                        wb_ack;
    logic [31:0]                 wb_dat;
  } lspec_state_t;

endpackage

// ===== verif/lspec_tracker_chk.sv
// Purpose: Port-level checks of the load speculation tracker
// Assumes: Outcome registered one cycle after each operation
// Notes:   Bound to every tracker instance
`timescale 1ns/10ps

module lspec_tracker_chk #(
  parameter int ADVANCED_LOAD_ADDRESS_TABLE_USED = 16
) (
  input wire logic                     core_clk, // Core clock
  input wire logic                     rst_b,    // Async reset, active low
  input wire lspec_pkg::lspec_wb_req_t wb_i,     // Bus request
  input wire lspec_pkg::lspec_wb_rsp_t wb_o,     // Bus answer
  input wire lspec_pkg::lspec_req_t    op_i,     // Issued operation
  input wire lspec_pkg::lspec_rsp_t    rsp_o     // Operation outcome
);
  wire [63:0] tgt_now = op_i.pc + {{32{op_i.offset[31]}}, op_i.offset};
  wire        chk_br  = op_i.valid && op_i.op == lspec_pkg::OP_CHECK_ADV_BR;
  wire        chk_ld  = op_i.valid && op_i.op == lspec_pkg::OP_CHECK_LOAD;
  wire        tst_fp  = op_i.valid && op_i.op == lspec_pkg::OP_TEST_FP;
  wire        fp_fill = op_i.valid && op_i.op == lspec_pkg::OP_FP_FILL;
  wire        csl_fp  = op_i.valid && op_i.op == lspec_pkg::OP_CTRL_SPEC_LOAD && op_i.fp_dst && op_i.fault;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_answer; op_i.valid && op_i.op inside {[4'h1:4'he]} |=> rsp_o.valid; endproperty
  a_answer: assert property (p_answer) else $error("no outcome after operation");
  property p_br_miss; chk_br |=> rsp_o.redirect == !rsp_o.hit; endproperty
  a_br_miss: assert property (p_br_miss) else $error("check branch redirect wrong");
  property p_br_tgt; chk_br |=> !rsp_o.redirect || rsp_o.target == $past(tgt_now); endproperty
  a_br_tgt: assert property (p_br_tgt) else $error("check branch target wrong");
  property p_reload; chk_ld |=> rsp_o.reload != rsp_o.hit && !rsp_o.redirect; endproperty
  a_reload: assert property (p_reload) else $error("check load reload wrong");
  property p_redir_src;
    rsp_o.redirect |-> $past(op_i.op) inside {lspec_pkg::OP_CHECK_ADV_BR, lspec_pkg::OP_SPEC_CHECK_BR};
  endproperty
  a_redir_src: assert property (p_redir_src) else $error("redirect from non-check op");
  property p_fault_src; rsp_o.cons_fault |-> $past(op_i.valid) && !$past(op_i.spec); endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault from speculative op");
  property p_test_fp;
    tst_fp |=> !rsp_o.cons_fault && rsp_o.test_set == ($past(op_i.fp_val) == lspec_pkg::DEFERRED_FAULT_FLOAT_VALUE);
  endproperty
  a_test_fp: assert property (p_test_fp) else $error("float test wrong");
  property p_fp_fill; fp_fill |=> rsp_o.fp_write && rsp_o.fp_result == $past(op_i.fp_val) && !rsp_o.cons_fault; endproperty
  a_fp_fill: assert property (p_fp_fill) else $error("float fill wrong");
  property p_fp_spec; csl_fp |=> rsp_o.fp_write && rsp_o.fp_result == lspec_pkg::DEFERRED_FAULT_FLOAT_VALUE; endproperty
  a_fp_spec: assert property (p_fp_spec) else $error("float deferred value missing");
endmodule

bind lspec_tracker lspec_tracker_chk #(.ADVANCED_LOAD_ADDRESS_TABLE_USED(ADVANCED_LOAD_ADDRESS_TABLE_USED)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .wb_i(wb_i), .wb_o(wb_o), .op_i(op_i), .rsp_o(rsp_o));

// ===== verif/lspec_stream_model.sv
// Purpose: Instruction stream issuing loads, stores and checks
// Assumes: Bench orders checks after their advanced loads
// Notes:   Idle fields are scrambled so nothing stale looks valid
`timescale 1ns/10ps

module lspec_stream_model (
  input  wire logic             core_clk, // Core clock
  output lspec_pkg::lspec_req_t op_o,     // Operation to tracker
  input  wire lspec_pkg::lspec_rsp_t rsp_i // Outcome from tracker
);
  initial op_o = '0;

  // Checks name the load's register and precede use
  // Collection saved and restored over the register bus
  task automatic issue(input lspec_pkg::lspec_req_t r, input int gap, output lspec_pkg::lspec_rsp_t q);
    lspec_pkg::lspec_req_t idle;
    idle = ~r;
    idle.valid = 1'b0;
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    op_o <= r;
    @(posedge core_clk);
    op_o <= idle;
    @(posedge core_clk);
    q = rsp_i;
  endtask
endmodule

// ===== verif/lspec_tracker_tb_top.sv
// Purpose: Self-checking bench of the load speculation tracker
// Assumes: Table limited to four entries to reach eviction
// Notes:   Row flags are {redirect, reload, cons_fault, test_set, fp_write}
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module lspec_tracker_tb_top;
  typedef struct packed {
    logic [3:0] op; logic [6:0] d; logic [6:0] s; logic [11:0] a; logic [1:0] z; logic [3:0] m; logic [4:0] e;
  } lspec_row_t;
  // m is {other kind, spec, fault, float}
  localparam lspec_row_t ROWS [27] = '{
    '{4'h1,7'h0a,7'h00,12'h100,2'h3,4'h0,5'h00}, '{4'h4,7'h0a,7'h00,12'h100,2'h3,4'h0,5'h00},
    '{4'h5,7'h0a,7'h00,12'h100,2'h3,4'h8,5'h10}, '{4'h7,7'h00,7'h00,12'h104,2'h0,4'h0,5'h00},
    '{4'h4,7'h0a,7'h00,12'h100,2'h3,4'h0,5'h08}, '{4'h1,7'h0b,7'h00,12'h200,2'h3,4'h0,5'h00},
    '{4'h7,7'h00,7'h00,12'h208,2'h3,4'h0,5'h00}, '{4'h5,7'h0b,7'h00,12'h200,2'h3,4'h0,5'h00},
    '{4'h1,7'h0b,7'h00,12'h300,2'h3,4'h0,5'h00}, '{4'h7,7'h00,7'h00,12'h300,2'h3,4'h0,5'h00},
    '{4'h5,7'h0b,7'h00,12'h300,2'h3,4'h0,5'h10}, '{4'h3,7'h14,7'h00,12'h000,2'h3,4'h2,5'h00},
    '{4'hd,7'h00,7'h14,12'h000,2'h3,4'h0,5'h02}, '{4'h6,7'h00,7'h14,12'h000,2'h3,4'h0,5'h10},
    '{4'hc,7'h15,7'h14,12'h000,2'h3,4'h4,5'h00}, '{4'hd,7'h00,7'h15,12'h000,2'h3,4'h0,5'h02},
    '{4'hc,7'h16,7'h15,12'h000,2'h3,4'h0,5'h04}, '{4'h6,7'h00,7'h05,12'h000,2'h3,4'h0,5'h00},
    '{4'h8,7'h00,7'h15,12'h1f8,2'h3,4'h0,5'h00}, '{4'h9,7'h1e,7'h00,12'h1f8,2'h3,4'h0,5'h00},
    '{4'hd,7'h00,7'h1e,12'h000,2'h3,4'h0,5'h02}, '{4'h2,7'h28,7'h00,12'h400,2'h3,4'h2,5'h00},
    '{4'h5,7'h28,7'h00,12'h400,2'h3,4'h0,5'h10}, '{4'he,7'h00,7'h00,12'h000,2'h3,4'h1,5'h02},
    '{4'hb,7'h03,7'h00,12'h000,2'h3,4'h1,5'h01}, '{4'h3,7'h03,7'h00,12'h000,2'h3,4'h3,5'h01},
    '{4'ha,7'h00,7'h03,12'h500,2'h3,4'h0,5'h00}};

  logic                     core_clk  = 1'b0;
  logic                     rst_b     = 1'b0;
  lspec_pkg::lspec_wb_req_t wbq       = '0;
  lspec_pkg::lspec_wb_rsp_t wb_o;
  lspec_pkg::lspec_req_t    op_i;
  lspec_pkg::lspec_rsp_t    rsp_o;
  int                       err_count = 0;
  int                       checks    = 0;
  logic [31:0]              rd;

  always #10 core_clk = ~core_clk;

  lspec_tracker #(.ADVANCED_LOAD_ADDRESS_TABLE_USED(4)) dut (.core_clk(core_clk), .rst_b(rst_b), .wb_i(wbq), .wb_o(wb_o),
    .op_i(op_i), .rsp_o(rsp_o));
  lspec_stream_model u_stream (.core_clk(core_clk), .op_o(op_i), .rsp_i(rsp_o));

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wbq <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do @(posedge core_clk); while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wbq <= '0;
  endtask

  task automatic exec(input lspec_row_t r);
    lspec_pkg::lspec_req_t q;
    lspec_pkg::lspec_rsp_t p;
    q = '0;
    q.valid = 1'b1;
    q.op = lspec_pkg::lspec_op_t'(r.op);
    q.dst = r.d;
    q.src1 = r.s;
    q.src2 = r.s;
    q.addr = 64'(r.a);
    q.size = r.z;
    q.kind = r.m[3] ? 2'h2 : 2'h1;
    q.spec = r.m[2];
    q.fault = r.m[1];
    q.fp_dst = r.m[0];
    q.fp_val = r.m[0] ? lspec_pkg::DEFERRED_FAULT_FLOAT_VALUE : 82'h1;
    q.pc = 64'h1000;
    q.offset = 32'hffff_fff0;
    u_stream.issue(q, checks % 3, p);
    `CHK("valid", 1'b1, p.valid)
    `CHK("flags", r.e, {p.redirect, p.reload, p.cons_fault, p.test_set, p.fp_write})
    if (r.e[4]) `CHK("target", 64'hff0, p.target)
    if (r.e[0]) `CHK("fp", lspec_pkg::DEFERRED_FAULT_FLOAT_VALUE, p.fp_result)
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) exec(ROWS[i]);
    wb(1'b0, lspec_pkg::REG_COLL_HI, 32'h0);
    `CHK("coll_hi", 32'h8000_0000, rd)
    wb(1'b1, lspec_pkg::REG_COLL_LO, 32'ha5a5_0f0f);
    wb(1'b0, lspec_pkg::REG_COLL_LO, 32'h0);
    `CHK("coll_lo", 32'ha5a5_0f0f, rd)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    exec('{4'h1, 7'h20, 7'h00, 12'h600, 2'h3, 4'h0, 5'h00});
    wb(1'b1, lspec_pkg::REG_CTRL, 32'h3);
    exec('{4'h5, 7'h20, 7'h00, 12'h600, 2'h3, 4'h0, 5'h10});
    wb(1'b1, lspec_pkg::REG_CTRL, 32'h0);
    exec('{4'h1, 7'h21, 7'h00, 12'h680, 2'h3, 4'h0, 5'h00});
    exec('{4'h5, 7'h21, 7'h00, 12'h680, 2'h3, 4'h0, 5'h10});
    wb(1'b1, lspec_pkg::REG_CTRL, 32'h2);
    for (int i = 0; i < 5; i++) exec('{4'h1, 7'h28 + 7'(i), 7'h00, 12'h700 + 12'(8 * i), 2'h3, 4'h0, 5'h00});
    wb(1'b0, lspec_pkg::REG_STATUS, 32'h0);
    `CHK("status", 32'h0000_000f, rd)
    exec('{4'h5, 7'h28, 7'h00, 12'h700, 2'h3, 4'h0, 5'h10});
    exec('{4'h5, 7'h2c, 7'h00, 12'h720, 2'h3, 4'h0, 5'h00});
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    wb(1'b0, lspec_pkg::REG_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    wb(1'b0, lspec_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", lspec_pkg::CTRL_RESET, rd)
    wb(1'b0, lspec_pkg::REG_COLL_HI, 32'h0);
    `CHK("coll_hi", lspec_pkg::COLL_RESET[63:32], rd)
    exec('{4'h5, 7'h2c, 7'h00, 12'h720, 2'h3, 4'h0, 5'h10});
    end_of_test();
  end
endmodule
